// ==== rtl/asr_readout.sv ====
// Status and axis output register readout of a three-axis motion sensor.
// Assumes the serial front end gives byte reads, START/STOP pulses and a
// registered interface selection; the sensing core delivers samples.
// Function
// - Strap caught at power-on selects bus address
// - Overwrite flag when unread sample replaced
// - Bit one shows clocks powered down
// - Bit five shows memory supply on
// - Bit six shows activity watch active
// - Bit seven shows activity detected, wake
// - Axes at 0x02..0x07, low then high
// - Sign bit copied to upper bits
// - No samples while no interface selected
// - FIFO output mapped, twelve bit limit
// - FIFO advances only on full 0x02..0x07 read
// - Outputs frozen from START to STOP
`timescale 1ns/1ns
module asr_readout
  import asr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic address_strap_pin_i,
  input wire logic i2c_select_i,
  input wire logic four_wire_serial_select_i,
  input wire logic three_wire_serial_select_i,
  input wire logic fifo_enable_i,
  input wire logic clocks_powered_down_i,
  input wire logic otp_supply_on_i,
  input wire logic activity_watch_active_i,
  input wire logic activity_event_i,
  input wire logic [SAMPLE_W-1:0] x_sample_i,
  input wire logic [SAMPLE_W-1:0] y_sample_i,
  input wire logic [SAMPLE_W-1:0] z_sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic bus_start_i,
  input wire logic bus_stop_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [6:0] bus_address_o,
  output logic continuous_wake_mode_o
);
  // ****************
  // State
  // ****************
  typedef struct packed {
    logic strap_caught;
    logic bus_address_strap;
    logic sample_overwritten;
    logic detected;
    logic wake;
    logic frozen;
    logic unread;
    logic [3:0] seq;
    logic [AXIS_W-1:0] x_accel_value;
    logic [AXIS_W-1:0] y_accel_value;
    logic [AXIS_W-1:0] z_accel_value;
    logic [7:0] rdata;
  } asr_st_t;
  asr_st_t s_q, s_d;

  function automatic logic [AXIS_W-1:0] sext14(input logic [SAMPLE_W-1:0] v);
    sext14 = {{(AXIS_W-SAMPLE_W){v[SAMPLE_W-1]}}, v};
  endfunction
  function automatic logic [AXIS_W-1:0] sext12(input logic [FIFO_RES_W-1:0] v);
    sext12 = {{(AXIS_W-FIFO_RES_W){v[FIFO_RES_W-1]}}, v};
  endfunction

  logic if_selected, fifo_in_ready, fifo_out_valid, fifo_pop, direct_take;
  logic [FIFO_W-1:0] fifo_out;
  logic [FIFO_W-1:0] fifo_in;
  logic [7:0] cond;

  assign if_selected = i2c_select_i | four_wire_serial_select_i
                     | three_wire_serial_select_i;
  // Truncate to the FIFO resolution so each stored axis stays twelve bits
  assign fifo_in = {x_sample_i[SAMPLE_W-1 -: FIFO_RES_W],
                    y_sample_i[SAMPLE_W-1 -: FIFO_RES_W],
                    z_sample_i[SAMPLE_W-1 -: FIFO_RES_W]};
  assign direct_take = sample_valid_i && !fifo_enable_i && if_selected && !s_q.frozen;
  // Back-pressure reaches the core when the FIFO is full
  assign sample_ready_o = fifo_enable_i ? fifo_in_ready : 1'b1;
  // Pop only after the last output byte of a complete walk
  assign fifo_pop = rd_en_i && (addr_i == Z_ACCEL_HIGH) && (s_q.seq == 4'h5)
                  && fifo_enable_i;

  asr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(!fifo_enable_i),
    .in_data_i(fifo_in),
    .in_valid_i(sample_valid_i && fifo_enable_i && if_selected),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop)
  );

  always_comb begin
    cond = '0;
    cond[OVR_BIT] = s_q.sample_overwritten;
    cond[CLKPD_BIT] = clocks_powered_down_i;
    cond[OTP_BIT] = otp_supply_on_i;
    cond[WATCH_BIT] = activity_watch_active_i;
    cond[DETECT_BIT] = s_q.detected;
  end

  always_comb begin
    s_d = s_q;
    // ****************
    // Strap capture
    // ****************
    if (!s_q.strap_caught) begin
      s_d.strap_caught = 1'b1;
      s_d.bus_address_strap = address_strap_pin_i;
    end
    // ****************
    // Transaction freeze
    // ****************
    if (bus_start_i) s_d.frozen = 1'b1;
    else if (bus_stop_i) s_d.frozen = 1'b0;
    if (bus_start_i) s_d.seq = '0;
    // ****************
    // Activity detect
    // ****************
    if (activity_event_i) begin
      s_d.detected = 1'b1;
      s_d.wake = 1'b1;
    end else if (!activity_watch_active_i) begin
      s_d.detected = 1'b0;
    end
    // ****************
    // Output register load
    // ****************
    if (direct_take) begin
      s_d.x_accel_value = sext14(x_sample_i);
      s_d.y_accel_value = sext14(y_sample_i);
      s_d.z_accel_value = sext14(z_sample_i);
      s_d.unread = 1'b1;
    end else if (fifo_enable_i && fifo_out_valid && !s_q.frozen) begin
      s_d.x_accel_value = sext12(fifo_out[FIFO_W-1 -: FIFO_RES_W]);
      s_d.y_accel_value = sext12(fifo_out[FIFO_W-FIFO_RES_W-1 -: FIFO_RES_W]);
      s_d.z_accel_value = sext12(fifo_out[FIFO_RES_W-1:0]);
    end
    // ****************
    // Register reads
    // ****************
    if (rd_en_i) begin
      unique case (addr_i)
        ADDR_STRAP_STATUS: s_d.rdata = {4'h0, s_q.bus_address_strap, 3'h0};
        DEV_COND_STATUS: s_d.rdata = cond;
        X_ACCEL_LOW: s_d.rdata = s_q.x_accel_value[7:0];
        X_ACCEL_HIGH: s_d.rdata = s_q.x_accel_value[15:8];
        Y_ACCEL_LOW: s_d.rdata = s_q.y_accel_value[7:0];
        Y_ACCEL_HIGH: s_d.rdata = s_q.y_accel_value[15:8];
        Z_ACCEL_LOW: s_d.rdata = s_q.z_accel_value[7:0];
        Z_ACCEL_HIGH: s_d.rdata = s_q.z_accel_value[15:8];
        default: s_d.rdata = 8'h00;
      endcase
      // Walk must step up one address at a time from the first axis byte
      if (addr_i == X_ACCEL_LOW) s_d.seq = 4'h1;
      else if (s_q.seq != 4'h0 && addr_i == X_ACCEL_LOW + 8'(s_q.seq))
        s_d.seq = 4'(s_q.seq + 1'b1);
      else s_d.seq = 4'h0;
      if (fifo_pop) s_d.seq = 4'h0;
      if (addr_i == DEV_COND_STATUS) s_d.sample_overwritten = 1'b0;
      if (addr_i >= X_ACCEL_LOW && addr_i <= Z_ACCEL_HIGH) s_d.unread = 1'b0;
    end
    // Set wins over the read clear
    if (direct_take && s_q.unread) s_d.sample_overwritten = 1'b1;
    // Writes to these read-only registers are dropped
    if (wr_en_i) s_d.rdata = s_d.rdata;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign bus_address_o = s_q.bus_address_strap ? ALT_ADDR : BASE_ADDR;
  assign continuous_wake_mode_o = s_q.wake;

  logic unused_w;
  assign unused_w = ^wdata_i ^ COND_RESET[0];
endmodule

// ==== rtl/asr_pkg.sv ====
// Package for the status and axis sample readout block.
// Assumes a byte-wide register port driven by the serial front end.
package asr_pkg;
  // ****************
  // Register map
  // ****************
  localparam logic [7:0] ADDR_STRAP_STATUS = 8'h00;
  localparam logic [7:0] DEV_COND_STATUS = 8'h01;
  localparam logic [7:0] X_ACCEL_LOW = 8'h02;
  localparam logic [7:0] X_ACCEL_HIGH = 8'h03;
  localparam logic [7:0] Y_ACCEL_LOW = 8'h04;
  localparam logic [7:0] Y_ACCEL_HIGH = 8'h05;
  localparam logic [7:0] Z_ACCEL_LOW = 8'h06;
  localparam logic [7:0] Z_ACCEL_HIGH = 8'h07;
  // ****************
  // Fields and values
  // ****************
  localparam int STRAP_BIT = 3;
  localparam int OVR_BIT = 0;
  localparam int CLKPD_BIT = 1;
  localparam int OTP_BIT = 5;
  localparam int WATCH_BIT = 6;
  localparam int DETECT_BIT = 7;
  localparam logic [6:0] BASE_ADDR = 7'h4c;
  localparam logic [6:0] ALT_ADDR = 7'h6c;
  localparam logic [7:0] COND_RESET = 8'h04;
  localparam int SAMPLE_W = 14;
  localparam int FIFO_RES_W = 12;
  localparam int AXIS_W = 16;
  localparam int FIFO_W = 3 * FIFO_RES_W;
  localparam int FIFO_DEPTH = 8;
endpackage

// ==== rtl/asr_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module asr_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } asr_fifo_st_t;
  asr_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;
  assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o = mem_q[s_q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    s_d = s_q;
    if (push) s_d.wr = AW'(s_q.wr + 1'b1);
    if (pop) s_d.rd = AW'(s_q.rd + 1'b1);
    s_d.cnt = (AW+1)'(s_q.cnt + push - pop);
    if (flush_i) s_d = '0;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) s_q <= '0;
    else s_q <= s_d;
  end
  // Storage has no reset; contents are qualified by the count
  always_ff @(posedge ref_clk_i) begin
    if (push) mem_q[s_q.wr] <= in_data_i;
  end
endmodule

// ==== bench/asr_readout_properties.sv ====
// Checker for the readout block, watching its ports only.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ns
module asr_readout_properties (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clocks_powered_down_i,
  input wire logic otp_supply_on_i,
  input wire logic activity_watch_active_i,
  input wire logic activity_event_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] rdata_o,
  input wire logic [6:0] bus_address_o,
  input wire logic continuous_wake_mode_o
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_strap_bit_read: assert property (rd_en_i && addr_i == 8'h00 |=>
    bus_address_o inside {7'h4c, 7'h6c} && rdata_o == {4'h0, bus_address_o == 7'h6c, 3'h0})
    else $error("strap bit and bus address disagree");
  // Strap is caught once, so the address may only move at the first edge
  a_strap_held: assert property ($past(rst_n_i, 2) |-> $stable(bus_address_o))
    else $error("bus address moved");
  a_cond_live: assert property (rd_en_i && addr_i == 8'h01 |=> rdata_o[6:1] ==
    {$past(activity_watch_active_i), $past(otp_supply_on_i), 3'h0, $past(clocks_powered_down_i)})
    else $error("condition bits wrong");
  a_wake_set: assert property (activity_event_i |=> continuous_wake_mode_o)
    else $error("wake not entered");
  a_wake_sticky: assert property (continuous_wake_mode_o |=> continuous_wake_mode_o)
    else $error("wake dropped");
  a_sign_copied: assert property (rd_en_i && addr_i inside {8'h03, 8'h05, 8'h07} |=>
    rdata_o[7:5] inside {3'h0, 3'h7}) else $error("high byte not sign extended");
  a_unmapped_zero: assert property (rd_en_i && addr_i > 8'h07 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rd_en_i |=> $stable(rdata_o))
    else $error("read data moved without read");
endmodule
bind asr_readout asr_readout_properties u_asr_readout_properties (.ref_clk_i, .rst_n_i,
  .clocks_powered_down_i, .otp_supply_on_i, .activity_watch_active_i, .activity_event_i,
  .rd_en_i, .addr_i, .rdata_o, .bus_address_o, .continuous_wake_mode_o);

// ==== bench/asr_host_model.sv ====
// Host model: register reads and writes, bus START and STOP marks.
// Assumes one clock; drives just after the rising edge.
`timescale 1ns/1ns
module asr_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output logic bus_start_o,
  output logic bus_stop_o,
  output logic rd_en_o,
  output logic wr_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // ****************
  // Bus tasks
  // ****************
  initial begin
    {bus_start_o, bus_stop_o, rd_en_o, wr_en_o, addr_o, wdata_o} = '0;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    {rd_en_o, addr_o} <= {1'b1, a};
    @(posedge ref_clk_i);
    {rd_en_o, addr_o} <= {1'b0, ~a};
    #1 d = rdata_i;
  endtask
  // Released lines show inverted data so a stale value cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    {wr_en_o, addr_o, wdata_o} <= {1'b1, a, v};
    @(posedge ref_clk_i);
    {wr_en_o, addr_o, wdata_o} <= {1'b0, ~a, ~v};
  endtask
  task automatic mark(input logic stop);
    @(posedge ref_clk_i);
    {bus_start_o, bus_stop_o} <= {~stop, stop};
    @(posedge ref_clk_i);
    {bus_start_o, bus_stop_o} <= 2'b00;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Testbench for the readout block: status reads, direct samples, freeze, FIFO.
// Assumes the host model makes every register access.
`timescale 1ns/1ns
module testbench;
  import asr_pkg::*;
  logic ref_clk_i, rst_n_i, address_strap_pin_i, i2c_select_i, four_wire_serial_select_i;
  logic three_wire_serial_select_i, fifo_enable_i, clocks_powered_down_i, otp_supply_on_i;
  logic activity_watch_active_i, activity_event_i, sample_valid_i, sample_ready_o;
  logic bus_start_i, bus_stop_i, rd_en_i, wr_en_i, continuous_wake_mode_o;
  logic [SAMPLE_W-1:0] x_sample_i, y_sample_i, z_sample_i;
  logic [7:0] addr_i, wdata_i, rdata_o, d;
  logic [6:0] bus_address_o;
  int fail_count, n_compared, acc;
  asr_readout u_asr_readout (.*);
  asr_host_model u_asr_host_model (.ref_clk_i, .rdata_i(rdata_o), .bus_start_o(bus_start_i),
    .bus_stop_o(bus_stop_i), .rd_en_o(rd_en_i), .wr_en_o(wr_en_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  // ****************
  // Helpers
  // ****************
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    u_asr_host_model.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic push(input logic [SAMPLE_W-1:0] x, y, z);
    @(posedge ref_clk_i);
    {x_sample_i, y_sample_i, z_sample_i, sample_valid_i} <= {x, y, z, 1'b1};
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b0;
  endtask
  task automatic t_regs();
    rc(8'h00, 8'h08);
    chk("bus address", 8'h6c, {1'b0, bus_address_o});
    u_asr_host_model.wr(8'h01, 8'hff);
    rc(8'h01, 8'h02);
    rc(8'h09, 8'h00);
    push(14'h1234, 14'h1234, 14'h1234);
    rc(8'h03, 8'h00);
  endtask
  task automatic t_direct();
    logic [7:0] e [6] = '{8'h00, 8'he0, 8'hff, 8'h1f, 8'h05, 8'h00};
    @(posedge ref_clk_i);
    i2c_select_i <= 1'b1;
    clocks_powered_down_i <= 1'b0;
    push(14'h2000, 14'h1fff, 14'h0005);
    u_asr_host_model.mark(1'b0);
    for (int a = 0; a < 6; a++) rc(8'(a + 2), e[a]);
    u_asr_host_model.mark(1'b1);
    rc(8'h01, 8'h00);
  endtask
  task automatic t_freeze();
    push(14'h0011, '0, '0);
    u_asr_host_model.mark(1'b0);
    push(14'h0022, '0, '0);
    rc(8'h02, 8'h11);
    u_asr_host_model.mark(1'b1);
    push(14'h0022, '0, '0);
    rc(8'h02, 8'h22);
    push(14'h0033, '0, '0);
    push(14'h0044, '0, '0);
    rc(8'h01, 8'h01);
    rc(8'h01, 8'h00);
  endtask
  task automatic t_status();
    @(posedge ref_clk_i);
    {otp_supply_on_i, activity_watch_active_i} <= 2'b11;
    rc(8'h01, 8'h60);
    @(posedge ref_clk_i);
    activity_event_i <= 1'b1;
    @(posedge ref_clk_i);
    activity_event_i <= 1'b0;
    rc(8'h01, 8'he0);
    chk("wake", 8'h01, {7'h0, continuous_wake_mode_o});
  endtask
  // Offers ten words to the 8-deep buffer, then drains it by full-range reads
  task automatic t_fifo();
    @(posedge ref_clk_i);
    fifo_enable_i <= 1'b1;
    {i2c_select_i, three_wire_serial_select_i} <= 2'b01;
    acc = 0;
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk_i);
      {x_sample_i, y_sample_i, z_sample_i, sample_valid_i} <= {{3{14'(i * 4)}}, 1'b1};
      @(negedge ref_clk_i);
      acc += int'(sample_ready_o);
    end
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b0;
    chk("accepted", 8'h08, 8'(acc));
    for (int i = 0; i < 8; i++) for (int a = 2; a < 8; a++) begin
      u_asr_host_model.rd(8'(a), d);
      if (a % 2 == 1) chk("fifo high", 8'h00, d);
      else chk("fifo low", 8'(i), d);
    end
    chk("ready", 8'h01, {7'h0, sample_ready_o});
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    {rst_n_i, i2c_select_i, four_wire_serial_select_i, three_wire_serial_select_i} = '0;
    {fifo_enable_i, otp_supply_on_i, activity_watch_active_i, activity_event_i} = '0;
    {address_strap_pin_i, clocks_powered_down_i, sample_valid_i} = 3'b110;
    {x_sample_i, y_sample_i, z_sample_i} = '0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_direct();
    t_freeze();
    t_status();
    t_fifo();
    test_done();
  end
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule
